// ---- hw/control_signal_source_select.sv ----
// Operation-mode driven source selector for drive function inputs
//
// Notes on behaviour
// - Every function input takes the source named by its own selection code.
// - Code 6 gives a constant active level.
// - Code 7 gives a constant inactive level.
// - Code 13 gives technology controller start, only in configurations 111, 211, 411.
// - Code 70 gives release from both safety paths; safe torque off always included.
// - Codes 71 to 75 give control inputs 2 to 6, or their remote values.
// - Code 76 gives multifunction input 1 when its mode is 3, or remote value.
// - Code 157 is active when any warning enabled in the mask is present.
// - Codes 158 and 159 give the first and second timer outputs.
// - Code 160 is active once the drive is initialised and ready.
// - Code 161 needs both safety paths, a start command and output frequency.
// - Code 162 gives operational fault; code 165 gives drive overload.
// - Code 163 is active when actual frequency reached reference frequency.
// - Code 164 is active while stator frequency exceeds the setting frequency.
// - Code 166 is active when heat sink reaches 80 degrees less its limit.
// - Code 168 gives the motor temperature warning as configured.
// - Code 169 is active while a critical general warning is shown.
// - Codes 171 and 173 give the first and second comparator results.
// - Codes 172 and 174 give the inverted comparator results.
// - Codes 175 to 177 give the three configured digital signals.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module control_signal_source_select
	import ctl_src_pkg::*;
#(
	parameter int NUM_FUNCS = 8
) (
	input  wire logic                             mclk,
	input  wire logic                             rst_n,
	input  wire logic                             control_input_2,
	input  wire logic                             control_input_3,
	input  wire logic                             control_input_4,
	input  wire logic                             control_input_5,
	input  wire logic                             control_input_6,
	input  wire logic                             multifunction_input_1_digital,
	input  wire logic                             safety_path_a,
	input  wire logic                             safety_path_b,
	input  wire ctl_src_pkg::flags_t              flags,
	input  wire logic [ctl_src_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [ctl_src_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                             reg_wr,
	input  wire logic                             reg_rd,
	output logic      [ctl_src_pkg::DATA_W-1:0]   reg_rdata,
	output logic      [NUM_FUNCS-1:0]             func_out
);

	import ctl_src_pkg::*;

	typedef struct packed {
		logic [NUM_FUNCS-1:0][CODE_W-1:0] code;
		logic [REMOTE_W-1:0]              remote_en;
		logic [REMOTE_W-1:0]              remote_val;
		logic [CODE_W-1:0]                multifunction_input_1_mode;
		logic [WARN_W-1:0]                warn_mask;
		logic [CFG_W-1:0]                 config_sel;
		logic [TEMP_W-1:0]                hs_limit;
		logic [TEMP_W-1:0]                in_limit;
		logic [FREQ_W-1:0]                set_freq;
		logic [NUM_FUNCS-1:0]             out;
		logic [DATA_W-1:0]                rdata;
	} state_t;

	state_t q;
	state_t d;

	// ****************************************
	// Pin synchronisation
	// ****************************************
	pin_sync_if #(.W(PIN_W)) pins ();

	assign pins.raw = {safety_path_b, safety_path_a, multifunction_input_1_digital,
		control_input_6, control_input_5, control_input_4, control_input_3,
		control_input_2};

	pin_sync #(.W(PIN_W)) u_sync (
		.mclk  (mclk),
		.rst_n (rst_n),
		.pins  (pins)
	);

	// ****************************************
	// Helpers
	// ****************************************
	// Limit is added to the reading rather than subtracted from the maximum,
	// so a limit above the maximum cannot wrap the threshold.
	function automatic logic temp_reached(input logic [TEMP_W-1:0] temp,
		input logic [TEMP_W-1:0] maxv, input logic [TEMP_W-1:0] lim);
		logic [TEMP_W:0] sum;
		sum = {1'b0, temp} + {1'b0, lim};
		return sum >= {1'b0, maxv};
	endfunction : temp_reached

	// Terminal level, overridden by the remote value when remote is enabled
	function automatic logic input_level(input int idx, input logic pin,
		input state_t s);
		return s.remote_en[idx] ? s.remote_val[idx] : pin;
	endfunction : input_level

	logic [PIN_W-1:0] pin_s;
	logic             release_sig;
	logic             tc_cfg_ok;
	logic             hs_warn;
	logic             in_warn;

	assign pin_s       = pins.sync;
	assign release_sig = pin_s[PIN_SA] & pin_s[PIN_SB];
	assign tc_cfg_ok   = (q.config_sel == CFG_TC_A) || (q.config_sel == CFG_TC_B) ||
		(q.config_sel == CFG_TC_C);
	assign hs_warn     = temp_reached(flags.heat_sink_temp, HS_TEMP_MAX, q.hs_limit);
	assign in_warn     = temp_reached(flags.inside_temp, IN_TEMP_MAX, q.in_limit);

	function automatic logic select_source(input logic [CODE_W-1:0] code,
		input state_t s);
		logic v;
		v = 1'b0;
		case (code)
			SEL_ON:         v = 1'b1;
			SEL_OFF:        v = 1'b0;
			SEL_TC_START:   v = tc_cfg_ok & flags.tc_start;
			SEL_RELEASE:    v = release_sig;
			SEL_IN2:        v = input_level(PIN_IN2, pin_s[PIN_IN2], s);
			SEL_IN3:        v = input_level(PIN_IN2 + 1, pin_s[PIN_IN2 + 1], s);
			SEL_IN4:        v = input_level(PIN_IN2 + 2, pin_s[PIN_IN2 + 2], s);
			SEL_IN5:        v = input_level(PIN_IN2 + 3, pin_s[PIN_IN2 + 3], s);
			SEL_IN6:        v = input_level(PIN_IN2 + 4, pin_s[PIN_IN2 + 4], s);
			SEL_MULTIFUNCTION_INPUT_1:       v = input_level(PIN_MULTIFUNCTION_INPUT_1,
				pin_s[PIN_MULTIFUNCTION_INPUT_1] & (s.multifunction_input_1_mode == MULTIFUNCTION_INPUT_1_DIGITAL), s);
			SEL_WARN_MASK:  v = |(flags.warnings & s.warn_mask);
			SEL_TIMER1:     v = flags.timer1;
			SEL_TIMER2:     v = flags.timer2;
			SEL_READY:      v = flags.ready;
			SEL_RUN:        v = release_sig & flags.start_cmd & flags.freq_avail;
			SEL_FAULT:      v = flags.fault;
			SEL_OVERLOAD:   v = flags.overload;
			SEL_FREQ_REACH: v = flags.freq_reached;
			SEL_SET_FREQ:   v = flags.stator_freq > s.set_freq;
			SEL_HS_TEMP:    v = hs_warn;
			SEL_IN_TEMP:    v = in_warn;
			SEL_OVER_TEMP:  v = hs_warn | in_warn;
			SEL_MOTOR_TEMP: v = flags.motor_temp_warn;
			SEL_GEN_WARN:   v = flags.general_warn;
			SEL_CMP1:       v = flags.cmp1;
			SEL_CMP2:       v = flags.cmp2;
			SEL_CMP1_N:     v = ~flags.cmp1;
			SEL_CMP2_N:     v = ~flags.cmp2;
			SEL_DSIG1:      v = flags.dsig1;
			SEL_DSIG2:      v = flags.dsig2;
			SEL_DSIG3:      v = flags.dsig3;
			default:        v = 1'b0;
		endcase
		return v;
	endfunction : select_source

	// ****************************************
	// Register port and selection
	// ****************************************
	logic                       code_hit;
	logic [$clog2(MAX_FUNCS)-1:0] code_idx;

	assign code_idx = reg_addr[$clog2(MAX_FUNCS)+1:2];
	assign code_hit = (reg_addr[ADDR_W-1:$clog2(MAX_FUNCS)+2] ==
		REG_CODE_BASE[ADDR_W-1:$clog2(MAX_FUNCS)+2]) && (32'(code_idx) < NUM_FUNCS);

	always_comb begin
		d       = q;
		d.rdata = '0;
		if (reg_wr) begin
			if (code_hit) begin
				d.code[code_idx] = reg_wdata[CODE_W-1:0];
			end
			case (reg_addr)
				REG_REMOTE: begin
					d.remote_en  = reg_wdata[REMOTE_W-1:0];
					d.remote_val = reg_wdata[REMOTE_VAL_LSB +: REMOTE_W];
				end
				REG_MULTIFUNCTION_INPUT_1_MODE: d.multifunction_input_1_mode  = reg_wdata[CODE_W-1:0];
				REG_WARN_MASK: d.warn_mask  = reg_wdata[WARN_W-1:0];
				REG_CONFIG:    d.config_sel = reg_wdata[CFG_W-1:0];
				REG_HS_LIMIT:  d.hs_limit   = reg_wdata[TEMP_W-1:0];
				REG_IN_LIMIT:  d.in_limit   = reg_wdata[TEMP_W-1:0];
				REG_SET_FREQ:  d.set_freq   = reg_wdata[FREQ_W-1:0];
				default: ;
			endcase
		end
		if (reg_rd) begin
			if (code_hit) begin
				d.rdata = DATA_W'(q.code[code_idx]);
			end else begin
				case (reg_addr)
					REG_REMOTE: begin
						d.rdata = DATA_W'(q.remote_en) |
							(DATA_W'(q.remote_val) << REMOTE_VAL_LSB);
					end
					REG_MULTIFUNCTION_INPUT_1_MODE:  d.rdata = DATA_W'(q.multifunction_input_1_mode);
					REG_WARN_MASK:  d.rdata = DATA_W'(q.warn_mask);
					REG_CONFIG:     d.rdata = DATA_W'(q.config_sel);
					REG_HS_LIMIT:   d.rdata = DATA_W'(q.hs_limit);
					REG_IN_LIMIT:   d.rdata = DATA_W'(q.in_limit);
					REG_SET_FREQ:   d.rdata = DATA_W'(q.set_freq);
					REG_OUT_STATUS: d.rdata = DATA_W'(q.out);
					REG_PIN_STATUS: d.rdata = DATA_W'(pin_s);
					default:        d.rdata = '0;
				endcase
			end
		end
		// Selection uses the codes already in force, so a new code acts one cycle later
		for (int i = 0; i < NUM_FUNCS; i++) begin
			d.out[i] = select_source(q.code[i], q);
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			for (int i = 0; i < NUM_FUNCS; i++) begin
				q.code[i] <= CODE_RESET;
			end
		end else begin
			q <= d;
		end
	end

	assign reg_rdata = q.rdata;
	assign func_out  = q.out;

	// ****************************************
	// Checks on function input 0
	// ****************************************
	AST_ON: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_ON) |=> func_out[0])
		else $error("Code on did not drive an active level");

	AST_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_OFF) |=> !func_out[0])
		else $error("Code off did not drive an inactive level");

	AST_TC_CFG: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_TC_START && !tc_cfg_ok) |=> !func_out[0])
		else $error("Controller start passed outside its configurations");

	AST_RELEASE: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_RELEASE) |=>
		func_out[0] == ($past(pin_s[PIN_SA]) && $past(pin_s[PIN_SB])))
		else $error("Release does not follow both safety paths");

	AST_REMOTE: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_IN2 && q.remote_en[PIN_IN2]) |=>
		func_out[0] == $past(q.remote_val[PIN_IN2]))
		else $error("Remote value did not override control input 2");

	AST_MULTIFUNCTION_INPUT_1_MODE: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_MULTIFUNCTION_INPUT_1 && !q.remote_en[PIN_MULTIFUNCTION_INPUT_1] &&
		q.multifunction_input_1_mode != MULTIFUNCTION_INPUT_1_DIGITAL) |=> !func_out[0])
		else $error("Multifunction input passed while not in digital mode");

	AST_MASK: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_WARN_MASK && (flags.warnings & q.warn_mask) == '0) |=>
		!func_out[0])
		else $error("Masked-out warnings raised the warning mask output");

	AST_RUN: assert property (@(posedge mclk) disable iff (!rst_n)
		($past(q.code[0]) == SEL_RUN && func_out[0]) |->
		$past(flags.start_cmd) && $past(flags.freq_avail) &&
		$past(pin_s[PIN_SA]) && $past(pin_s[PIN_SB]))
		else $error("Run signal active without its conditions");

	AST_SET_FREQ: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_SET_FREQ && flags.stator_freq == q.set_freq) |=> !func_out[0])
		else $error("Setting frequency active at equal frequency");

	AST_HS_TEMP: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_HS_TEMP && q.hs_limit == '0 &&
		flags.heat_sink_temp == HS_TEMP_MAX) |=> func_out[0])
		else $error("Heat sink warning missed at its maximum");

	AST_NEG_CMP: assert property (@(posedge mclk) disable iff (!rst_n)
		(q.code[0] == SEL_CMP1_N) |=> func_out[0] != $past(flags.cmp1))
		else $error("Negated comparator output is not inverted");

	AST_LATENCY: assert property (@(posedge mclk) disable iff (!rst_n)
		(reg_wr && code_hit && code_idx == '0 && reg_wdata[CODE_W-1:0] == SEL_ON)
		##1 (q.code[0] == SEL_ON) |=> func_out[0])
		else $error("New code not in force one cycle after it was stored");

endmodule : control_signal_source_select

// ---- hw/ctl_src_pkg.sv ----
// Constants, selection codes and register map of the control signal source selector
package ctl_src_pkg;

	// ****************************************
	// Widths
	// ****************************************
	localparam int CODE_W   = 8;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	localparam int TEMP_W   = 8;
	localparam int FREQ_W   = 16;
	localparam int CFG_W    = 16;
	localparam int WARN_W   = 9;
	localparam int PIN_W    = 8;
	localparam int REMOTE_W = 6;

	// ****************************************
	// Selection codes
	// ****************************************
	localparam logic [CODE_W-1:0] SEL_ON         = 8'h06;
	localparam logic [CODE_W-1:0] SEL_OFF        = 8'h07;
	localparam logic [CODE_W-1:0] SEL_TC_START   = 8'h0d;
	localparam logic [CODE_W-1:0] SEL_RELEASE    = 8'h46;
	localparam logic [CODE_W-1:0] SEL_IN2        = 8'h47;
	localparam logic [CODE_W-1:0] SEL_IN3        = 8'h48;
	localparam logic [CODE_W-1:0] SEL_IN4        = 8'h49;
	localparam logic [CODE_W-1:0] SEL_IN5        = 8'h4a;
	localparam logic [CODE_W-1:0] SEL_IN6        = 8'h4b;
	localparam logic [CODE_W-1:0] SEL_MULTIFUNCTION_INPUT_1       = 8'h4c;
	localparam logic [CODE_W-1:0] SEL_WARN_MASK  = 8'h9d;
	localparam logic [CODE_W-1:0] SEL_TIMER1     = 8'h9e;
	localparam logic [CODE_W-1:0] SEL_TIMER2     = 8'h9f;
	localparam logic [CODE_W-1:0] SEL_READY      = 8'ha0;
	localparam logic [CODE_W-1:0] SEL_RUN        = 8'ha1;
	localparam logic [CODE_W-1:0] SEL_FAULT      = 8'ha2;
	localparam logic [CODE_W-1:0] SEL_FREQ_REACH = 8'ha3;
	localparam logic [CODE_W-1:0] SEL_SET_FREQ   = 8'ha4;
	localparam logic [CODE_W-1:0] SEL_OVERLOAD   = 8'ha5;
	localparam logic [CODE_W-1:0] SEL_HS_TEMP    = 8'ha6;
	localparam logic [CODE_W-1:0] SEL_IN_TEMP    = 8'ha7;
	localparam logic [CODE_W-1:0] SEL_MOTOR_TEMP = 8'ha8;
	localparam logic [CODE_W-1:0] SEL_GEN_WARN   = 8'ha9;
	localparam logic [CODE_W-1:0] SEL_OVER_TEMP  = 8'haa;
	localparam logic [CODE_W-1:0] SEL_CMP1       = 8'hab;
	localparam logic [CODE_W-1:0] SEL_CMP1_N     = 8'hac;
	localparam logic [CODE_W-1:0] SEL_CMP2       = 8'had;
	localparam logic [CODE_W-1:0] SEL_CMP2_N     = 8'hae;
	localparam logic [CODE_W-1:0] SEL_DSIG1      = 8'haf;
	localparam logic [CODE_W-1:0] SEL_DSIG2      = 8'hb0;
	localparam logic [CODE_W-1:0] SEL_DSIG3      = 8'hb1;

	// ****************************************
	// Fixed values
	// ****************************************
	localparam logic [CFG_W-1:0]  CFG_TC_A      = 16'h006f;
	localparam logic [CFG_W-1:0]  CFG_TC_B      = 16'h00d3;
	localparam logic [CFG_W-1:0]  CFG_TC_C      = 16'h019b;
	localparam logic [TEMP_W-1:0] HS_TEMP_MAX   = 8'h50;
	localparam logic [TEMP_W-1:0] IN_TEMP_MAX   = 8'h41;
	localparam logic [CODE_W-1:0] MULTIFUNCTION_INPUT_1_DIGITAL  = 8'h03;

	// ****************************************
	// Pin bit positions
	// ****************************************
	localparam int PIN_IN2  = 0;
	localparam int PIN_MULTIFUNCTION_INPUT_1 = 5;
	localparam int PIN_SA   = 6;
	localparam int PIN_SB   = 7;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [ADDR_W-1:0] REG_CODE_BASE  = 8'h00;
	localparam logic [ADDR_W-1:0] REG_REMOTE     = 8'h40;
	localparam logic [ADDR_W-1:0] REG_MULTIFUNCTION_INPUT_1_MODE  = 8'h44;
	localparam logic [ADDR_W-1:0] REG_WARN_MASK  = 8'h48;
	localparam logic [ADDR_W-1:0] REG_CONFIG     = 8'h4c;
	localparam logic [ADDR_W-1:0] REG_HS_LIMIT   = 8'h50;
	localparam logic [ADDR_W-1:0] REG_IN_LIMIT   = 8'h54;
	localparam logic [ADDR_W-1:0] REG_SET_FREQ   = 8'h58;
	localparam logic [ADDR_W-1:0] REG_OUT_STATUS = 8'h5c;
	localparam logic [ADDR_W-1:0] REG_PIN_STATUS = 8'h60;
	localparam int                MAX_FUNCS      = 16;
	localparam int                REMOTE_VAL_LSB = 8;
	localparam logic [CODE_W-1:0] CODE_RESET     = 8'h07;

	// Internal flags from the rest of the drive, all on mclk
	typedef struct packed {
		logic                tc_start;
		logic                timer1;
		logic                timer2;
		logic                ready;
		logic                start_cmd;
		logic                freq_avail;
		logic                fault;
		logic                freq_reached;
		logic                overload;
		logic                motor_temp_warn;
		logic                general_warn;
		logic                cmp1;
		logic                cmp2;
		logic                dsig1;
		logic                dsig2;
		logic                dsig3;
		logic [WARN_W-1:0]   warnings;
		logic [FREQ_W-1:0]   stator_freq;
		logic [TEMP_W-1:0]   heat_sink_temp;
		logic [TEMP_W-1:0]   inside_temp;
	} flags_t;

endpackage : ctl_src_pkg

// ---- hw/pin_sync.sv ----
// Two-stage synchroniser for asynchronous terminal pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 8
) (
	input  wire logic mclk,
	input  wire logic rst_n,
	pin_sync_if.syncer pins
);

	typedef struct packed {
		logic [W-1:0] ff1;
		logic [W-1:0] ff2;
	} sync_state_t;

	sync_state_t q;
	sync_state_t d;

	// ****************************************
	// Synchroniser
	// ****************************************
	always_comb begin
		d     = q;
		d.ff1 = pins.raw;
		d.ff2 = q.ff1;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pins.sync = q.ff2;

	AST_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(rst_n, 2) |-> pins.sync == $past(pins.raw, 2))
		else $error("Pin synchroniser delay is not two cycles");

endmodule : pin_sync

// ---- hw/pin_sync_if.sv ----
// Carrier between the pin synchroniser and the selector
`timescale 1ns/1ps
interface pin_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport syncer (input raw, output sync);
	modport user   (output raw, input sync);
endinterface : pin_sync_if

// ---- tb/drive_side_model.sv ----
// Behavioural model of the terminal pins and the drive firmware flags
`timescale 1ns/1ps
module drive_side_model
	import ctl_src_pkg::*;
(
	input  wire logic                            mclk,
	input  wire logic [ctl_src_pkg::PIN_W-1:0]   pin_lvl,
	input  wire ctl_src_pkg::flags_t             flag_req,
	output wire logic                            control_input_2,
	output wire logic                            control_input_3,
	output wire logic                            control_input_4,
	output wire logic                            control_input_5,
	output wire logic                            control_input_6,
	output wire logic                            multifunction_input_1_digital,
	output wire logic                            safety_path_a,
	output wire logic                            safety_path_b,
	output ctl_src_pkg::flags_t                  flags
);
	// Terminals move off the clock grid, so the synchroniser sees a real async edge
	assign #1.7 {safety_path_b, safety_path_a, multifunction_input_1_digital, control_input_6,
		control_input_5, control_input_4, control_input_3, control_input_2} = pin_lvl;

	// Firmware flags are produced on mclk, just after the edge
	always_ff @(posedge mclk) begin
		flags <= flag_req;
	end
endmodule : drive_side_model

// ---- tb/test_control_signal_source_select.sv ----
// Self-checking bench of the control signal source selector
`timescale 1ns/1ps
module test_control_signal_source_select;
	import ctl_src_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic                mclk = 1'b0;
	logic                rst_n = 1'b0;
	logic [PIN_W-1:0]    pin_lvl = 8'h00;
	flags_t              fl = '0;
	flags_t              flags;
	logic [ADDR_W-1:0]   reg_addr = 8'h00;
	logic [DATA_W-1:0]   reg_wdata = 32'h0;
	logic                reg_wr = 1'b0;
	logic                reg_rd = 1'b0;
	logic [DATA_W-1:0]   reg_rdata;
	logic [7:0]          func_out;
	logic                in2, in3, in4, in5, in6, multifunction_input_1, sa, sb;
	logic [DATA_W-1:0]   rem, mask, cfg, hs_lim, in_lim, setf, mode;
	logic [DATA_W-1:0]   exp_q[$];
	logic                rd_q = 1'b0;
	int                  n_mismatch = 0;
	int                  tests_run = 0;
	logic [CODE_W-1:0]   tbl[34] = '{SEL_ON, SEL_OFF, SEL_TC_START, SEL_RELEASE, SEL_IN2, SEL_IN3,
		SEL_IN4, SEL_IN5, SEL_IN6, SEL_MULTIFUNCTION_INPUT_1, SEL_WARN_MASK, SEL_TIMER1, SEL_TIMER2, SEL_READY,
		SEL_RUN, SEL_FAULT, SEL_FREQ_REACH, SEL_SET_FREQ, SEL_OVERLOAD, SEL_HS_TEMP, SEL_IN_TEMP,
		SEL_MOTOR_TEMP, SEL_GEN_WARN, SEL_OVER_TEMP, SEL_CMP1, SEL_CMP1_N, SEL_CMP2, SEL_CMP2_N,
		SEL_DSIG1, SEL_DSIG2, SEL_DSIG3, 8'h00, 8'h4d, 8'hff};
	logic [CODE_W-1:0]   code[8];

	always #2.5 mclk = ~mclk;

	drive_side_model partner (.mclk(mclk), .pin_lvl(pin_lvl), .flag_req(fl),
		.control_input_2(in2), .control_input_3(in3), .control_input_4(in4),
		.control_input_5(in5), .control_input_6(in6), .multifunction_input_1_digital(multifunction_input_1),
		.safety_path_a(sa), .safety_path_b(sb), .flags(flags));

	control_signal_source_select #(.NUM_FUNCS(8)) dut (.mclk(mclk), .rst_n(rst_n),
		.control_input_2(in2), .control_input_3(in3), .control_input_4(in4),
		.control_input_5(in5), .control_input_6(in6), .multifunction_input_1_digital(multifunction_input_1),
		.safety_path_a(sa), .safety_path_b(sb), .flags(flags), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.func_out(func_out));

	// ****************************************
	// Checking
	// ****************************************
	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Read data stands only in the cycle after the strobe, so it is taken at the next edge
	always @(posedge mclk) begin
		if (rd_q) begin
			check("reg_rdata", reg_rdata, exp_q.pop_front());
		end
		rd_q <= reg_rd & rst_n;
	end

	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : close_out

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		@(posedge mclk);
		exp_q.push_back(exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
	endtask : rd

	// Reference of one selected level, worked out from the stimulus
	function automatic logic exp_bit(input logic [CODE_W-1:0] c);
		int k;
		k = int'(c) - int'(SEL_IN2);
		if (c >= SEL_IN2 && c <= SEL_IN6) return rem[k] ? rem[8+k] : pin_lvl[k];
		case (c)
			SEL_ON:         return 1'b1;
			SEL_OFF:        return 1'b0;
			SEL_TC_START:   return fl.tc_start && (cfg[15:0] == CFG_TC_A || cfg[15:0] == CFG_TC_B
				|| cfg[15:0] == CFG_TC_C);
			SEL_RELEASE:    return pin_lvl[PIN_SA] & pin_lvl[PIN_SB];
			SEL_MULTIFUNCTION_INPUT_1:       return rem[5] ? rem[13] : pin_lvl[PIN_MULTIFUNCTION_INPUT_1] && mode[7:0] == 8'h03;
			SEL_WARN_MASK:  return |(mask[8:0] & fl.warnings);
			SEL_TIMER1:     return fl.timer1;
			SEL_TIMER2:     return fl.timer2;
			SEL_READY:      return fl.ready;
			SEL_RUN:        return pin_lvl[PIN_SA] & pin_lvl[PIN_SB] & fl.start_cmd &
				fl.freq_avail;
			SEL_FAULT:      return fl.fault;
			SEL_OVERLOAD:   return fl.overload;
			SEL_FREQ_REACH: return fl.freq_reached;
			SEL_SET_FREQ:   return fl.stator_freq > setf[15:0];
			SEL_HS_TEMP:    return 9'(fl.heat_sink_temp) + 9'(hs_lim[7:0]) >= 9'(HS_TEMP_MAX);
			SEL_IN_TEMP:    return 9'(fl.inside_temp) + 9'(in_lim[7:0]) >= 9'(IN_TEMP_MAX);
			SEL_OVER_TEMP:  return exp_bit(SEL_HS_TEMP) | exp_bit(SEL_IN_TEMP);
			SEL_MOTOR_TEMP: return fl.motor_temp_warn;
			SEL_GEN_WARN:   return fl.general_warn;
			SEL_CMP1:       return fl.cmp1;
			SEL_CMP2:       return fl.cmp2;
			SEL_CMP1_N:     return ~fl.cmp1;
			SEL_CMP2_N:     return ~fl.cmp2;
			SEL_DSIG1:      return fl.dsig1;
			SEL_DSIG2:      return fl.dsig2;
			SEL_DSIG3:      return fl.dsig3;
			default:        return 1'b0;
		endcase
	endfunction : exp_bit

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [DATA_W-1:0] w;
		flags_t            f;
		void'($urandom(32'h66da6149));
		repeat (12) @(posedge mclk);
		rst_n <= 1'b1;
		rd(REG_CODE_BASE, 32'(CODE_RESET));
		rd(REG_OUT_STATUS, 32'h0);
		rd(8'h20, 32'h0);
		rd(8'h80, 32'h0);
		// Latency of a code write: output moves on the edge after the write edge
		wr(REG_CODE_BASE, 32'(SEL_ON));
		#1 check("func_out0", 32'(func_out[0]), 32'h0);
		@(posedge mclk);
		#1 check("func_out0", 32'(func_out[0]), 32'h1);
		wr(REG_OUT_STATUS, 32'h0);
		rd(REG_OUT_STATUS, 32'h1);
		for (int it = 0; it < 40; it++) begin
			pin_lvl <= 8'($urandom);
			f = $bits(flags_t)'({$urandom, $urandom});
			// Every third pass sits exactly on the heat sink maximum with no limit
			if (it % 3 == 0) f.heat_sink_temp = HS_TEMP_MAX;
			fl <= f;
			rem = $urandom & ((it % 4 == 1) ? 32'h1f3f : 32'h3f3f);
			mode = (it % 2 == 0) ? 32'h3 : 32'($urandom % 3);
			mask = (it % 10 == 0) ? 32'h0 : 32'($urandom % 512);
			cfg = (it % 4 == 0) ? 32'h7 : (it % 4 == 1) ? 32'(CFG_TC_A) :
				(it % 4 == 2) ? 32'(CFG_TC_B) : 32'(CFG_TC_C);
			hs_lim = (it % 3 == 0) ? 32'h0 : 32'($urandom % 256);
			in_lim = 32'($urandom % 256);
			setf = 32'($urandom % 65536);
			wr(REG_REMOTE, rem);
			wr(REG_MULTIFUNCTION_INPUT_1_MODE, mode);
			wr(REG_WARN_MASK, mask);
			wr(REG_CONFIG, cfg);
			wr(REG_HS_LIMIT, hs_lim);
			wr(REG_IN_LIMIT, in_lim);
			if (it % 5 == 2) setf = 32'(fl.stator_freq);
			wr(REG_SET_FREQ, setf);
			for (int i = 0; i < 8; i++) begin
				code[i] = tbl[(it * 9 + i) % 34];
				wr(REG_CODE_BASE + 8'(4 * i), 32'(code[i]));
			end
			repeat (5) @(posedge mclk);
			w = 32'h0;
			for (int i = 0; i < 8; i++) w[i] = exp_bit(code[i]);
			rd(REG_OUT_STATUS, w);
			rd(REG_PIN_STATUS, 32'(pin_lvl));
			rd(REG_CODE_BASE + 8'h1c, 32'(code[7]));
			rd(REG_REMOTE, rem);
			rd(REG_SET_FREQ, setf);
		end
		repeat (3) @(posedge mclk);
		// Mid-run reset must bring codes, remote values and outputs back to reset state
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rd(REG_CODE_BASE + 8'h1c, 32'(CODE_RESET));
		rd(REG_REMOTE, 32'h0);
		rd(REG_OUT_STATUS, 32'h0);
		repeat (3) @(posedge mclk);
		close_out();
	end

	// Whole run is under two thousand cycles; this bound only catches a hang
	initial begin
		#(20000 * 5);
		n_mismatch++;
		close_out();
	end
endmodule : test_control_signal_source_select
